/* File: verilog/acc_pkg.sv */
// Purpose: Shared constants for the comparator control block
// Assumes: Byte address is four times the register index
// Notes: Indices below are register indices, not byte addresses
package acc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [5:0] IDX_DIN_DISABLE = 6'h01;
    localparam logic [5:0] IDX_CONV_CTRL_B = 6'h03;
    localparam logic [5:0] IDX_COMP_CTRL = 6'h08;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRLB_MUX_EN_BIT = 6;
    localparam int CTRLB_BUSY_BIT = 7;
    localparam int CMP_POWER_OFF_BIT = 7;
    localparam int CMP_BANDGAP_BIT = 6;
    localparam int CMP_OUT_BIT = 5;
    localparam int CMP_FLAG_BIT = 4;
    localparam int CMP_IRQ_EN_BIT = 3;
    localparam int CMP_MODE_HI_BIT = 1;
    localparam int CMP_MODE_LO_BIT = 0;
    localparam int DIN_NEG_OFF_BIT = 5;
    localparam int DIN_POS_OFF_BIT = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRLB_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] DIN_RESET = 2'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // ------------------------------------------------------------
    // Event modes and channel codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE = 2'h0,
        ACC_MODE_RESVD = 2'h1,
        ACC_MODE_FALL = 2'h2,
        ACC_MODE_RISE = 2'h3
    } acc_mode_t;
    localparam logic [2:0] CHAN_LAST_PIN = 3'h3;
    localparam int SYNC_STAGES = 2;
endpackage : acc_pkg

/* File: verilog/acc_sync.sv */
// Purpose: Two-flop level synchroniser
// Assumes: Input may change at any time
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module acc_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic d_i,
    output logic q_o
);
    import acc_pkg::*;

    logic meta_reg;
    logic sync_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;
endmodule : acc_sync

/* File: verilog/acc_edge.sv */
// Purpose: Output event detector for the comparator
// Assumes: Level is already synchronised
// Notes: Reserved mode never fires
`timescale 1ns/10ps
module acc_edge (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Level and mode
    input wire logic level_i,
    input wire acc_pkg::acc_mode_t mode_i,
    // Event
    output logic event_o
);
    import acc_pkg::*;

    logic prev_reg;
    logic rise_w;
    logic fall_w;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_i;
        end
    end

    assign rise_w = level_i & ~prev_reg;
    assign fall_w = ~level_i & prev_reg;
    assign event_o = (mode_i == ACC_MODE_TOGGLE) ? (rise_w | fall_w) :
                     (mode_i == ACC_MODE_FALL) ? fall_w :
                     (mode_i == ACC_MODE_RISE) ? rise_w : 1'b0;
endmodule : acc_edge

/* File: verilog/acc_top.sv */
// Purpose: Control logic around the analog comparator
// Assumes: Register strobes are one cycle, read data one cycle later
// Notes: Analog switches sit outside; this block drives their selects
//
// Contract
// - Mux on, converter off, channel code 0 to 3: analog pin chosen
// - Otherwise the dedicated negative pin
// - Power-off bit 7 switches comparator off
// - Bandgap select replaces positive pin
// - Output synchronised, one to two cycles
// - Selected edge type sets event flag
// - Irq needs flag, enable and global enable
// - Flag cleared by vector or one-write
// - Mode codes: toggle, reserved, fall, rise
// - Reserved bits read as zero
// - Buffer-off bits force port input zero
// - Output high when positive exceeds negative
`timescale 1ns/10ps
module acc_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [acc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [acc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [acc_pkg::DATA_W-1:0] rdata_o,
    // Converter state
    input wire logic converter_on_i,
    input wire logic [2:0] channel_select_i,
    // Processor interrupt path
    input wire logic global_irq_en_i,
    input wire logic irq_ack_i,
    output logic irq_o,
    // Analog side
    input wire logic comp_raw_i,
    output logic comparator_power_off_o,
    output logic bandgap_select_o,
    output logic neg_from_analog_o,
    output logic [1:0] neg_channel_o,
    // Port pins
    input wire logic [1:0] pin_in_i,
    output logic [1:0] pin_buffer_off_o,
    output logic [1:0] pin_read_o
);
    import acc_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Two edges of delay so no flop leaves reset on its own
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [5:0] idx_w = addr_i[7:2];
    wire aligned_w = (addr_i[1:0] == 2'h0);
    wire hit_ctrlb_w = aligned_w && (idx_w == IDX_CONV_CTRL_B);
    wire hit_comp_w = aligned_w && (idx_w == IDX_COMP_CTRL);
    wire hit_din_w = aligned_w && (idx_w == IDX_DIN_DISABLE);
    wire wr_ctrlb_w = wr_i && hit_ctrlb_w;
    wire wr_comp_w = wr_i && hit_comp_w;
    wire wr_din_w = wr_i && hit_din_w;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [6:0] ctrlb_reg;
    logic power_off_reg;
    logic bandgap_reg;
    logic flag_reg;
    logic flag_next;
    logic irq_en_reg;
    acc_mode_t mode_reg;
    logic [1:0] din_off_reg;
    logic irq_reg;
    logic neg_analog_reg;
    logic [1:0] neg_chan_reg;
    logic [1:0] pin_read_reg;
    logic [7:0] rdata_reg;
    logic comp_sync;
    logic comp_event;

    // ------------------------------------------------------------
    // Comparator output path
    // ------------------------------------------------------------
    // Raw level is high while positive input exceeds negative input
    acc_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(comp_raw_i),
        .q_o(comp_sync)
    );

    acc_edge u_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .level_i(comp_sync),
        .mode_i(mode_reg),
        .event_o(comp_event)
    );

    // ------------------------------------------------------------
    // Negative input routing
    // ------------------------------------------------------------
    // Codes above the last pin fall back to the dedicated pin
    wire mux_en_w = ctrlb_reg[CTRLB_MUX_EN_BIT];
    wire chan_ok_w = (channel_select_i <= CHAN_LAST_PIN);
    wire neg_analog_w = mux_en_w && !converter_on_i && chan_ok_w;
    wire [1:0] neg_chan_w = neg_analog_w ? channel_select_i[1:0] : 2'h0;

    // ------------------------------------------------------------
    // Event flag
    // ------------------------------------------------------------
    // A new event beats a clear in the same cycle
    wire flag_clr_w = irq_ack_i || (wr_comp_w && wdata_i[CMP_FLAG_BIT]);
    assign flag_next = comp_event || (flag_reg && !flag_clr_w);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire [7:0] comp_rd_w = {power_off_reg, bandgap_reg, comp_sync, flag_reg,
                            irq_en_reg, 1'b0, mode_reg};
    wire [7:0] ctrlb_rd_w = {1'b0, ctrlb_reg};
    wire [7:0] din_rd_w = {2'h0, din_off_reg, 4'h0};
    wire [7:0] rd_sel_w = hit_comp_w ? comp_rd_w :
                          hit_ctrlb_w ? ctrlb_rd_w :
                          hit_din_w ? din_rd_w : READ_UNMAPPED;

    // ------------------------------------------------------------
    // Per-pin input buffer gating
    // ------------------------------------------------------------
    logic [1:0] pin_read_next;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            assign pin_read_next[gi] = pin_in_i[gi] & ~din_off_reg[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrlb_reg <= CTRLB_RESET[6:0];
            din_off_reg <= DIN_RESET;
        end else begin
            if (wr_ctrlb_w) begin
                ctrlb_reg <= wdata_i[6:0];
            end
            if (wr_din_w) begin
                din_off_reg <= {wdata_i[DIN_NEG_OFF_BIT], wdata_i[DIN_POS_OFF_BIT]};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            power_off_reg <= 1'b0;
            bandgap_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            mode_reg <= ACC_MODE_TOGGLE;
        end else if (wr_comp_w) begin
            power_off_reg <= wdata_i[CMP_POWER_OFF_BIT];
            bandgap_reg <= wdata_i[CMP_BANDGAP_BIT];
            irq_en_reg <= wdata_i[CMP_IRQ_EN_BIT];
            mode_reg <= acc_mode_t'({wdata_i[CMP_MODE_HI_BIT], wdata_i[CMP_MODE_LO_BIT]});
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            irq_reg <= flag_reg && irq_en_reg && global_irq_en_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            neg_analog_reg <= 1'b0;
            neg_chan_reg <= 2'h0;
            pin_read_reg <= 2'h0;
            rdata_reg <= READ_UNMAPPED;
        end else begin
            neg_analog_reg <= neg_analog_w;
            neg_chan_reg <= neg_chan_w;
            pin_read_reg <= pin_read_next;
            rdata_reg <= rd_i ? rd_sel_w : READ_UNMAPPED;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign comparator_power_off_o = power_off_reg;
    assign bandgap_select_o = bandgap_reg;
    assign neg_from_analog_o = neg_analog_reg;
    assign neg_channel_o = neg_chan_reg;
    assign pin_buffer_off_o = din_off_reg;
    assign pin_read_o = pin_read_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    a_neg_analog_route: assert property (
        (ctrlb_reg[CTRLB_MUX_EN_BIT] && !converter_on_i && channel_select_i <= 3'h3)
        |=> (neg_from_analog_o && neg_channel_o == $past(channel_select_i[1:0])))
        else $error("analog pin not routed to negative input");

    a_neg_pin_default: assert property (
        (!ctrlb_reg[CTRLB_MUX_EN_BIT] || converter_on_i) |=> !neg_from_analog_o)
        else $error("dedicated negative pin not selected");

    a_power_off_write: assert property (
        (wr_i && hit_comp_w) |=> comparator_power_off_o == $past(wdata_i[7]))
        else $error("power-off bit not taken from write");

    a_bandgap_write: assert property (
        (wr_i && hit_comp_w) |=> bandgap_select_o == $past(wdata_i[6]))
        else $error("bandgap select not taken from write");

    a_sync_two_cycles: assert property (
        $stable(comp_raw_i)[*3] |-> comp_sync == comp_raw_i)
        else $error("synchronised output not settled after two cycles");

    a_event_sets_flag: assert property (
        comp_event |=> flag_reg)
        else $error("event did not set flag");

    a_irq_gating: assert property (
        ##1 irq_o == $past(flag_reg && irq_en_reg && global_irq_en_i))
        else $error("interrupt request not gated correctly");

    a_flag_clear_one: assert property (
        (flag_reg && !comp_event && (irq_ack_i || (wr_comp_w && wdata_i[4])))
        |=> !flag_reg)
        else $error("flag not cleared");

    a_flag_zero_write: assert property (
        (flag_reg && !irq_ack_i && wr_comp_w && !wdata_i[4]) |=> flag_reg)
        else $error("zero write cleared flag");

    a_mode_reserved: assert property (
        (mode_reg == ACC_MODE_RESVD) |-> !comp_event)
        else $error("reserved mode produced an event");

    a_rise_mode: assert property (
        (mode_reg == ACC_MODE_RISE && comp_event) |-> (comp_sync && !$past(comp_sync)))
        else $error("rise mode fired on wrong edge");

    a_reserved_zero: assert property (
        (rd_i && hit_comp_w) |=> !rdata_o[2])
        else $error("reserved control bit read non-zero");

    a_reserved_din: assert property (
        (rd_i && hit_din_w) |=> rdata_o[7:6] == 2'h0)
        else $error("reserved disable bits read non-zero");

    a_pin_forced_low: assert property (
        din_off_reg[1] |=> !pin_read_o[1])
        else $error("disabled pin read as one");

    a_edge_toggle: assert property (
        (mode_reg == ACC_MODE_TOGGLE) |-> comp_event == (comp_sync != $past(comp_sync)))
        else $error("toggle detection mismatch");

    a_fall_mode: assert property (
        (mode_reg == ACC_MODE_FALL && comp_event) |-> (!comp_sync && $past(comp_sync)))
        else $error("fall mode fired on wrong edge");

    a_flag_holds: assert property (
        (flag_reg && !flag_clr_w) |=> flag_reg)
        else $error("flag dropped without a clear");

    a_flag_quiet: assert property (
        (!flag_reg && !comp_event) |=> !flag_reg)
        else $error("flag set without an event");

    a_irq_global_off: assert property (
        !global_irq_en_i |=> !irq_o)
        else $error("interrupt raised with global enable off");

    a_irq_enable_off: assert property (
        !irq_en_reg |=> !irq_o)
        else $error("interrupt raised with comparator enable off");

    // Codes past the last pin must never reach the analog switches
    a_high_code_pin: assert property (
        (channel_select_i > CHAN_LAST_PIN) |=> !neg_from_analog_o)
        else $error("high channel code routed an analog pin");

    a_chan_idle_zero: assert property (
        !neg_from_analog_o |-> (neg_channel_o == 2'h0))
        else $error("channel select not parked at zero");

    a_sync_bit_read: assert property (
        (rd_i && hit_comp_w) |=> (rdata_o[CMP_OUT_BIT] == $past(comp_sync)))
        else $error("read output bit differs from synchronised level");

    a_din_write: assert property (
        wr_din_w |=> (pin_buffer_off_o ==
            $past({wdata_i[DIN_NEG_OFF_BIT], wdata_i[DIN_POS_OFF_BIT]})))
        else $error("buffer-off bits not taken from write");

    a_pin_pass_pos: assert property (
        !din_off_reg[0] |=> (pin_read_o[0] == $past(pin_in_i[0])))
        else $error("enabled pin not passed through");

    a_pin_forced_pos: assert property (
        din_off_reg[0] |=> !pin_read_o[0])
        else $error("disabled positive pin read as one");

    a_power_hold: assert property (
        !wr_comp_w |=> $stable(comparator_power_off_o))
        else $error("power-off changed without a write");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_irq_raised: cover property (irq_o);
    c_rise_event: cover property (mode_reg == ACC_MODE_RISE && comp_event);
    c_analog_route: cover property (neg_from_analog_o && neg_channel_o == 2'h3);
    c_set_beats_clear: cover property (comp_event && flag_clr_w);
    c_fall_event: cover property (mode_reg == ACC_MODE_FALL && comp_event);
endmodule : acc_top

/* File: dv/tb_analog_comparator_control.sv */
// Purpose: Self-checking bench for the comparator control block
// Assumes: Register reads return data one cycle after the strobe
// Notes: Byte address is the register index shifted left by two
`timescale 1ns/10ps
module tb_analog_comparator_control;
    import acc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_DIN = {IDX_DIN_DISABLE, 2'b00};
    localparam logic [7:0] A_CTB = {IDX_CONV_CTRL_B, 2'b00};
    localparam logic [7:0] A_CMP = {IDX_COMP_CTRL, 2'b00};
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic converter_on_i = 1'b0;
    logic [2:0] channel_select_i = 3'h0;
    logic global_irq_en_i = 1'b1;
    logic irq_ack_i = 1'b0;
    logic irq_o;
    logic comp_raw_i = 1'b0;
    logic comparator_power_off_o;
    logic bandgap_select_o;
    logic neg_from_analog_o;
    logic [1:0] neg_channel_o;
    logic [1:0] pin_in_i = 2'h3;
    logic [1:0] pin_buffer_off_o;
    logic [1:0] pin_read_o;
    int errors = 0;
    int n_tests = 0;

    always #50 clk_i = ~clk_i;

    acc_top dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .converter_on_i(converter_on_i),
        .channel_select_i(channel_select_i), .global_irq_en_i(global_irq_en_i),
        .irq_ack_i(irq_ack_i), .irq_o(irq_o), .comp_raw_i(comp_raw_i),
        .comparator_power_off_o(comparator_power_off_o),
        .bandgap_select_o(bandgap_select_o), .neg_from_analog_o(neg_from_analog_o),
        .neg_channel_o(neg_channel_o), .pin_in_i(pin_in_i),
        .pin_buffer_off_o(pin_buffer_off_o), .pin_read_o(pin_read_o)
    );
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task chk_out(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: output %h expected %h", $time, got, exp);
        end
    endtask : chk_out

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk_reg(rdata_o, exp);
    endtask : rd

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(A_CMP, 8'h00);
        settle(1);
        chk_reg(rdata_o, 8'h00);
        rd(A_CTB, 8'h00);
        rd(A_DIN, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h21, 8'h00);
        $display("Test reset done");
    endtask : t_reset

    task t_regs;
        wr(A_CMP, 8'hE7);
        settle(1);
        chk_out({2'b00, comparator_power_off_o, bandgap_select_o}, 4'h3);
        rd(A_CMP, 8'hC3);
        wr(A_CMP, 8'h00);
        settle(1);
        chk_out({2'b00, comparator_power_off_o, bandgap_select_o}, 4'h0);
        chk_out({2'b00, pin_read_o}, 4'h3);
        wr(A_DIN, 8'hFF);
        rd(A_DIN, 8'h30);
        chk_out({pin_buffer_off_o, pin_read_o}, 4'hC);
        wr(A_DIN, 8'h10);
        settle(2);
        chk_out({pin_buffer_off_o, pin_read_o}, 4'h6);
        @(posedge clk_i);
        pin_in_i <= 2'h1;
        settle(2);
        chk_out({pin_buffer_off_o, pin_read_o}, 4'h4);
        wr(A_CTB, 8'hFF);
        wr(8'h0D, 8'h00);
        rd(A_CTB, 8'h7F);
        rd(8'h0D, 8'h00);
        $display("Test registers done");
    endtask : t_regs

    task t_mux;
        for (int ch = 0; ch < 5; ch++) begin
            @(posedge clk_i);
            channel_select_i <= 3'(ch);
            settle(2);
            if (ch < 4) chk_out({1'b0, neg_from_analog_o, neg_channel_o}, 4'(4 + ch));
            else chk_out({1'b0, neg_from_analog_o, neg_channel_o}, 4'h0);
        end
        @(posedge clk_i);
        channel_select_i <= 3'h2;
        converter_on_i <= 1'b1;
        settle(2);
        chk_out({1'b0, neg_from_analog_o, neg_channel_o}, 4'h0);
        @(posedge clk_i);
        converter_on_i <= 1'b0;
        settle(2);
        chk_out({1'b0, neg_from_analog_o, neg_channel_o}, 4'h6);
        wr(A_CTB, 8'h00);
        settle(1);
        chk_out({1'b0, neg_from_analog_o, neg_channel_o}, 4'h0);
        $display("Test mux done");
    endtask : t_mux

    // Mode is written with the enable low first, so no stray interrupt
    task ev(input logic [1:0] m, input logic v, input logic ex);
        wr(A_CMP, {6'h00, m});
        wr(A_CMP, {4'h0, 1'b1, 1'b0, m});
        @(posedge clk_i);
        comp_raw_i <= v;
        settle(6);
        chk_out({3'b000, irq_o}, {3'b000, ex});
        rd(A_CMP, {2'b00, v, ex, 1'b1, 1'b0, m});
        if (ex) begin
            wr(A_CMP, {4'h0, 1'b1, 1'b0, m});
            rd(A_CMP, {2'b00, v, 1'b1, 1'b1, 1'b0, m});
            @(posedge clk_i);
            irq_ack_i <= 1'b1;
            @(posedge clk_i);
            irq_ack_i <= 1'b0;
            settle(2);
            chk_out({3'b000, irq_o}, 4'h0);
            rd(A_CMP, {2'b00, v, 1'b0, 1'b1, 1'b0, m});
        end
        // Enable dropped here so the next mode change is safe
        wr(A_CMP, {6'h00, m});
    endtask : ev

    task t_events;
        for (int m = 0; m < 4; m++) begin
            ev(2'(m), 1'b1, (m == 0) || (m == 3));
            ev(2'(m), 1'b0, (m == 0) || (m == 2));
        end
        $display("Test events done");
    endtask : t_events

    task t_gate;
        wr(A_CMP, 8'h00);
        @(posedge clk_i);
        global_irq_en_i <= 1'b0;
        comp_raw_i <= 1'b1;
        settle(6);
        chk_out({3'b000, irq_o}, 4'h0);
        rd(A_CMP, 8'h30);
        wr(A_CMP, 8'h08);
        settle(3);
        chk_out({3'b000, irq_o}, 4'h0);
        @(posedge clk_i);
        global_irq_en_i <= 1'b1;
        settle(3);
        chk_out({3'b000, irq_o}, 4'h1);
        wr(A_CMP, 8'h18);
        settle(3);
        chk_out({3'b000, irq_o}, 4'h0);
        rd(A_CMP, 8'h28);
        // Falling event lands on the same edge as a one-write clear
        @(posedge clk_i);
        comp_raw_i <= 1'b0;
        @(posedge clk_i);
        wr(A_CMP, 8'h18);
        rd(A_CMP, 8'h18);
        chk_out({3'b000, irq_o}, 4'h1);
        $display("Test gating done");
    endtask : t_gate
    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task test_done;
        $display("Comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_regs();
        t_mux();
        t_events();
        t_gate();
        test_done();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #500000;
        errors++;
        $display("Error %0t: watchdog expired", $time);
        test_done();
    end
endmodule : tb_analog_comparator_control
